// *** common/fwsr_defs.vh ***
// fwsr_defs.vh: constants of the flash status-polling controller
// assumes a 50 MHz aclk and a word-mode flash with 20 address bits
`ifndef FWSR_DEFS_VH
`define FWSR_DEFS_VH

// clock and flash bus timing, times in ns
`define FWSR_CLK_NS 20
`define FWSR_T_RC_NS 55
`define FWSR_T_WP_NS 35
`define FWSR_T_WPH_NS 20
`define FWSR_T_OEH_NS 10
// least times round up to whole cycles
`define FWSR_RD_CYC ((`FWSR_T_RC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WP_CYC ((`FWSR_T_WP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WPH_CYC ((`FWSR_T_WPH_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_OEH_CYC ((`FWSR_T_OEH_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
// data pins pass two synchroniser stages before sampling
`define FWSR_SYNC_CYC 2

// register offsets
`define FWSR_REG_CTRL 8'h00
`define FWSR_REG_ADDR 8'h04
`define FWSR_REG_WDATA 8'h08
`define FWSR_REG_STATUS 8'h0C
`define FWSR_REG_RDATA 8'h10

// control register fields
`define FWSR_CTRL_OP_LSB 0
`define FWSR_CTRL_CONT 8
`define FWSR_CTRL_ABORT 9

// opcodes
`define FWSR_OP_NONE 3'h0
`define FWSR_OP_WRITE 3'h1
`define FWSR_OP_READ 3'h2
`define FWSR_OP_POLL 3'h3
`define FWSR_OP_RESET 3'h4
`define FWSR_OP_SECTOR 3'h5
`define FWSR_OP_TIMER 3'h6

// status register fields
`define FWSR_ST_BUSY 0
`define FWSR_ST_OK 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_TIMER 3
`define FWSR_ST_NOT_ACC 4
`define FWSR_ST_RDY 5
`define FWSR_ST_TOG2 6
`define FWSR_ST_PENDING 7

// status bit positions on the flash data bus
`define FWSR_DQ_POLL 7
`define FWSR_DQ_TOG1 6
`define FWSR_DQ_FAIL 5
`define FWSR_DQ_TMR 3
`define FWSR_DQ_TOG2 2

// reset command word written to return the flash to array reads
`define FWSR_RESET_CMD 16'h00F0

// AXI responses
`define FWSR_RESP_OKAY 2'b00
`define FWSR_RESP_SLVERR 2'b10

`endif

// *** core/fwsr_bus_cycle.v ***
// fwsr_bus_cycle: runs one read or one write cycle on the flash pins
// assumes the flash is asynchronous; dq inputs arrive from outside aclk
`timescale 1ns/100ps
`default_nettype none
`include "fwsr_defs.vh"

module fwsr_bus_cycle (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// request
	input wire start,
	input wire is_write,
	input wire [19:0] addr,
	input wire [15:0] wdata,
	output reg done,
	output reg [15:0] rdata,
	// flash pins
	output reg [19:0] flash_addr,
	input wire [15:0] flash_dq_i,
	output reg [15:0] flash_dq_o,
	output reg flash_dq_oe,
	output reg flash_ce_n,
	output reg flash_oe_n,
	output reg flash_we_n
);

localparam [2:0] C_IDLE = 3'b001;
localparam [2:0] C_ACT = 3'b010;
localparam [2:0] C_HOLD = 3'b100;
// cycle lengths in aclk periods; cut to the counter width on use
localparam integer WP_LEN = `FWSR_WP_CYC;
localparam integer RD_LEN = `FWSR_RD_CYC + `FWSR_SYNC_CYC;
localparam integer GAP_LEN = `FWSR_WPH_CYC + `FWSR_OEH_CYC;

reg [2:0] st_q;
reg [3:0] cnt_q;
reg wr_q;
reg [15:0] dq_s1_q;
reg [15:0] dq_s2_q;

////////////////////////////////////////////////////////////////////////
// data pin synchroniser, only the second stage is sampled
always @(posedge aclk) begin
	if (!aresetn) begin
		dq_s1_q <= 16'h0000;
		dq_s2_q <= 16'h0000;
	end else begin
		dq_s1_q <= flash_dq_i;
		dq_s2_q <= dq_s1_q;
	end
end

////////////////////////////////////////////////////////////////////////
// cycle sequencer; ce and oe rise together so every read is a full
// completed cycle, which is what makes the toggle bit advance
always @(posedge aclk) begin
	if (!aresetn) begin
		st_q <= C_IDLE;
		cnt_q <= 4'h0;
		wr_q <= 1'b0;
		done <= 1'b0;
		rdata <= 16'h0000;
		flash_addr <= 20'h0_0000;
		flash_dq_o <= 16'h0000;
		flash_dq_oe <= 1'b0;
		flash_ce_n <= 1'b1;
		flash_oe_n <= 1'b1;
		flash_we_n <= 1'b1;
	end else begin
		done <= 1'b0;
		case (st_q)
		C_IDLE: begin
			if (start) begin
				st_q <= C_ACT;
				wr_q <= is_write;
				flash_addr <= addr;
				flash_ce_n <= 1'b0;
				if (is_write) begin
					flash_we_n <= 1'b0;
					flash_dq_o <= wdata;
					flash_dq_oe <= 1'b1;
					cnt_q <= WP_LEN[3:0];
				end else begin
					flash_oe_n <= 1'b0;
					// access time plus synchroniser latency
					cnt_q <= RD_LEN[3:0];
				end
			end
		end
		C_ACT: begin
			if (cnt_q == 4'h1) begin
				if (!wr_q) begin
					rdata <= dq_s2_q;
				end
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				flash_we_n <= 1'b1;
				st_q <= C_HOLD;
				// gap covers write pulse high and status oe hold
				cnt_q <= GAP_LEN[3:0];
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
		C_HOLD: begin
			flash_dq_oe <= 1'b0;
			if (cnt_q == 4'h1) begin
				st_q <= C_IDLE;
				done <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
		default: begin
			st_q <= C_IDLE;
		end
		endcase
	end
end

endmodule
`default_nettype wire

// *** core/fwsr_ctrl.v ***
// fwsr_ctrl: host controller that issues flash cycles and runs the
// toggle-bit status algorithm, ordered by software over AXI4-Lite
// assumes software loads ADDR with a valid status address before polling
//
// Summary of operation
// - status check always begins with two back-to-back full bus reads
// - toggling after the pair with fail bit high triggers a recheck
// - still toggling on recheck means failure; reset command is written
// - a resumed or restarted poll begins again with a fresh read pair
// - after failure flash stays out of array reads until reset command
// - timer bit may be skipped only if sector commands come under 50 us
// - timer bit is checked before and after each added sector command
// - status reads use the program address or an erasing sector address
`timescale 1ns/100ps
`default_nettype none
`include "fwsr_defs.vh"

module fwsr_ctrl (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address and data
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output reg s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output reg s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	// axi4-lite read
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output reg s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	// flash pins
	output wire [19:0] flash_addr,
	input wire [15:0] flash_dq_i,
	output wire [15:0] flash_dq_o,
	output wire flash_dq_oe,
	output wire flash_ce_n,
	output wire flash_oe_n,
	output wire flash_we_n,
	input wire ready_busy_pin
);

localparam [8:0] S_IDLE = 9'b0_0000_0001;
localparam [8:0] S_SINGLE = 9'b0_0000_0010;
localparam [8:0] S_RD1 = 9'b0_0000_0100;
localparam [8:0] S_RD2 = 9'b0_0000_1000;
localparam [8:0] S_CHK = 9'b0_0001_0000;
localparam [8:0] S_RST = 9'b0_0010_0000;
localparam [8:0] S_PRE = 9'b0_0100_0000;
localparam [8:0] S_SECT = 9'b0_1000_0000;
localparam [8:0] S_POST = 9'b1_0000_0000;

// register address decode, used by both channels
function map_ok;
	input [7:0] a;
	begin
		map_ok = (a == `FWSR_REG_CTRL) || (a == `FWSR_REG_ADDR) ||
			(a == `FWSR_REG_WDATA) || (a == `FWSR_REG_STATUS) ||
			(a == `FWSR_REG_RDATA);
	end
endfunction

reg [8:0] st_q;
reg [19:0] addr_q;
reg [15:0] wdat_q;
reg cont_q;
reg abort_q;
reg ok_q;
reg fail_q;
reg tmr_q;
reg not_acc_q;
reg tog2_q;
reg pend_q;
reg [15:0] rd_q;
reg [15:0] first_q;
reg go_q;
reg go_wr_q;
reg [15:0] go_dat_q;
reg [7:0] awaddr_q;
reg aw_got_q;
reg [31:0] wd_q;
reg [3:0] ws_q;
reg w_got_q;
reg rb_s1_q;
reg rb_s2_q;
wire cyc_done;
wire [15:0] cyc_rdata;
wire wr_fire;
wire [2:0] op;
wire tog1;
wire [31:0] status;

////////////////////////////////////////////////////////////////////////
fwsr_bus_cycle u_cyc (
	.aclk(aclk),
	.aresetn(aresetn),
	.start(go_q),
	.is_write(go_wr_q),
	.addr(addr_q),
	.wdata(go_dat_q),
	.done(cyc_done),
	.rdata(cyc_rdata),
	.flash_addr(flash_addr),
	.flash_dq_i(flash_dq_i),
	.flash_dq_o(flash_dq_o),
	.flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n),
	.flash_we_n(flash_we_n)
);

////////////////////////////////////////////////////////////////////////
// ready_busy_pin is open drain and asynchronous, so synchronise it
always @(posedge aclk) begin
	if (!aresetn) begin
		rb_s1_q <= 1'b1;
		rb_s2_q <= 1'b1;
	end else begin
		rb_s1_q <= ready_busy_pin;
		rb_s2_q <= rb_s1_q;
	end
end

////////////////////////////////////////////////////////////////////////
// axi4-lite write: address and data taken in either order
assign wr_fire = aw_got_q && w_got_q && !s_bvalid;
assign op = wd_q[`FWSR_CTRL_OP_LSB +: 3];

always @(posedge aclk) begin
	if (!aresetn) begin
		s_awready <= 1'b0;
		s_wready <= 1'b0;
		s_bvalid <= 1'b0;
		s_bresp <= `FWSR_RESP_OKAY;
		aw_got_q <= 1'b0;
		w_got_q <= 1'b0;
		awaddr_q <= 8'h00;
		wd_q <= 32'h0000_0000;
		ws_q <= 4'h0;
	end else begin
		s_awready <= !aw_got_q && !(s_awvalid && s_awready);
		s_wready <= !w_got_q && !(s_wvalid && s_wready);
		if (s_awvalid && s_awready) begin
			aw_got_q <= 1'b1;
			awaddr_q <= s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			w_got_q <= 1'b1;
			wd_q <= s_wdata;
			ws_q <= s_wstrb;
		end
		if (wr_fire) begin
			s_bvalid <= 1'b1;
			s_bresp <= map_ok(awaddr_q) ? `FWSR_RESP_OKAY :
				`FWSR_RESP_SLVERR;
		end else if (s_bvalid && s_bready) begin
			s_bvalid <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// axi4-lite read
assign status = {24'h00_0000, pend_q, tog2_q, rb_s2_q, not_acc_q,
	tmr_q, fail_q, ok_q, !st_q[0]};

always @(posedge aclk) begin
	if (!aresetn) begin
		s_arready <= 1'b0;
		s_rvalid <= 1'b0;
		s_rdata <= 32'h0000_0000;
		s_rresp <= `FWSR_RESP_OKAY;
	end else begin
		if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rresp <= map_ok(s_araddr) ? `FWSR_RESP_OKAY :
				`FWSR_RESP_SLVERR;
			case (s_araddr)
			`FWSR_REG_CTRL: s_rdata <= {22'h00_0000, abort_q, cont_q,
				8'h00};
			`FWSR_REG_ADDR: s_rdata <= {12'h000, addr_q};
			`FWSR_REG_WDATA: s_rdata <= {16'h0000, wdat_q};
			`FWSR_REG_STATUS: s_rdata <= status;
			`FWSR_REG_RDATA: s_rdata <= {16'h0000, rd_q};
			default: s_rdata <= 32'h0000_0000;
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end else if (!s_rvalid) begin
			s_arready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// sequencer; a fresh command word is refused while busy
assign tog1 = first_q[`FWSR_DQ_TOG1] ^ cyc_rdata[`FWSR_DQ_TOG1];

always @(posedge aclk) begin
	if (!aresetn) begin
		st_q <= S_IDLE;
		addr_q <= 20'h0_0000;
		wdat_q <= 16'h0000;
		cont_q <= 1'b0;
		abort_q <= 1'b0;
		ok_q <= 1'b0;
		fail_q <= 1'b0;
		tmr_q <= 1'b0;
		not_acc_q <= 1'b0;
		tog2_q <= 1'b0;
		pend_q <= 1'b0;
		rd_q <= 16'h0000;
		first_q <= 16'h0000;
		go_q <= 1'b0;
		go_wr_q <= 1'b0;
		go_dat_q <= 16'h0000;
	end else begin
		go_q <= 1'b0;
		if (wr_fire && st_q[0]) begin
			if (awaddr_q == `FWSR_REG_ADDR) begin
				addr_q <= wd_q[19:0];
			end
			if (awaddr_q == `FWSR_REG_WDATA) begin
				wdat_q <= wd_q[15:0];
			end
		end
		if (wr_fire && awaddr_q == `FWSR_REG_CTRL && ws_q[1]) begin
			abort_q <= wd_q[`FWSR_CTRL_ABORT];
		end
		if (cyc_done && !go_wr_q) begin
			rd_q <= cyc_rdata;
		end
		case (st_q)
		S_IDLE: begin
			abort_q <= 1'b0;
			if (wr_fire && awaddr_q == `FWSR_REG_CTRL && ws_q[0] &&
				op != `FWSR_OP_NONE) begin
				cont_q <= wd_q[`FWSR_CTRL_CONT];
				ok_q <= 1'b0;
				fail_q <= 1'b0;
				not_acc_q <= 1'b0;
				pend_q <= 1'b0;
				go_q <= 1'b1;
				go_wr_q <= 1'b0;
				go_dat_q <= wdat_q;
				case (op)
				`FWSR_OP_WRITE: begin
					go_wr_q <= 1'b1;
					st_q <= S_SINGLE;
				end
				`FWSR_OP_RESET: begin
					go_wr_q <= 1'b1;
					go_dat_q <= `FWSR_RESET_CMD;
					st_q <= S_RST;
				end
				`FWSR_OP_POLL: st_q <= S_RD1;
				`FWSR_OP_SECTOR: st_q <= S_PRE;
				`FWSR_OP_TIMER: st_q <= S_POST;
				default: st_q <= S_SINGLE;
				endcase
			end
		end
		S_SINGLE: begin
			if (cyc_done) begin
				ok_q <= 1'b1;
				st_q <= S_IDLE;
			end
		end
		S_RD1: begin
			if (cyc_done) begin
				first_q <= cyc_rdata;
				go_q <= 1'b1;
				st_q <= S_RD2;
			end
		end
		S_RD2: begin
			if (cyc_done) begin
				tog2_q <= first_q[`FWSR_DQ_TOG2] ^
					cyc_rdata[`FWSR_DQ_TOG2];
				if (!tog1) begin
					ok_q <= 1'b1;
					st_q <= S_IDLE;
				end else if (cyc_rdata[`FWSR_DQ_FAIL]) begin
					first_q <= cyc_rdata;
					go_q <= 1'b1;
					st_q <= S_CHK;
				end else if (cont_q && !abort_q) begin
					go_q <= 1'b1;
					st_q <= S_RD1;
				end else begin
					pend_q <= 1'b1;
					st_q <= S_IDLE;
				end
			end
		end
		S_CHK: begin
			if (cyc_done) begin
				if (!tog1) begin
					ok_q <= 1'b1;
					st_q <= S_IDLE;
				end else begin
					fail_q <= 1'b1;
					go_q <= 1'b1;
					go_wr_q <= 1'b1;
					go_dat_q <= `FWSR_RESET_CMD;
					st_q <= S_RST;
				end
			end
		end
		S_RST: begin
			if (cyc_done) begin
				ok_q <= !fail_q;
				go_wr_q <= 1'b0;
				st_q <= S_IDLE;
			end
		end
		S_PRE: begin
			// window closed already: the extra command would be ignored
			if (cyc_done) begin
				tmr_q <= cyc_rdata[`FWSR_DQ_TMR];
				if (cyc_rdata[`FWSR_DQ_TMR]) begin
					not_acc_q <= 1'b1;
					st_q <= S_IDLE;
				end else begin
					go_q <= 1'b1;
					go_wr_q <= 1'b1;
					go_dat_q <= wdat_q;
					st_q <= S_SECT;
				end
			end
		end
		S_SECT: begin
			if (cyc_done) begin
				go_q <= 1'b1;
				go_wr_q <= 1'b0;
				st_q <= S_POST;
			end
		end
		S_POST: begin
			if (cyc_done) begin
				tmr_q <= cyc_rdata[`FWSR_DQ_TMR];
				if (go_dat_q == wdat_q && op == `FWSR_OP_SECTOR) begin
					not_acc_q <= cyc_rdata[`FWSR_DQ_TMR];
				end
				ok_q <= 1'b1;
				st_q <= S_IDLE;
			end
		end
		default: begin
			st_q <= S_IDLE;
		end
		endcase
	end
end

endmodule
`default_nettype wire

// *** dv/fwsr_ctrl_sva.sv ***
// fwsr_ctrl_sva: port-level checks of the flash status controller
// assumes one clock, aclk, and the synchronous active-low aresetn
`timescale 1ns/100ps
`default_nettype none

module fwsr_ctrl_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite
	input wire logic s_awready,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic s_rvalid,
	input wire logic s_rready,
	// flash pins
	input wire logic [19:0] flash_addr,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////
	a_b_hold: assert property (s_bvalid && !s_bready |=>
		s_bvalid && $stable(s_bresp)) else $error("bvalid dropped early");
	a_r_hold: assert property (s_rvalid && !s_rready |=>
		s_rvalid && $stable(s_rdata)) else $error("rvalid dropped early");
	a_r_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer late");
	a_w_block: assert property (s_bvalid |-> !s_awready && !s_wready)
		else $error("second write taken");
	////////////////////////////////////////////////////////////////////
	// a status read must be long enough for the sampled bits to settle
	a_read_len: assert property ($fell(flash_oe_n) |->
		(!flash_oe_n && !flash_ce_n) [*5] ##1 flash_oe_n)
		else $error("flash read length wrong");
	a_read_gap: assert property ($rose(flash_oe_n) |->
		(flash_oe_n && flash_ce_n) [*2]) else $error("read gap short");
	a_addr_hold: assert property (!flash_ce_n && !$past(flash_ce_n)
		|-> $stable(flash_addr)) else $error("address moved in cycle");
	a_write_len: assert property ($fell(flash_we_n) |->
		(!flash_we_n && flash_dq_oe && flash_oe_n) [*2] ##1
		(flash_we_n && flash_ce_n) [*2]) else $error("write pulse wrong");
	a_no_fight: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("host drives dq during read");
endmodule

bind fwsr_ctrl fwsr_ctrl_sva u_sva (.*);

`default_nettype wire

// *** dv/fwsr_flash_model.sv ***
// fwsr_flash_model: flash device answering status reads while busy
// assumes bench pulses load to start a program that, with fmode low, stays busy for nrd+1 reads
`timescale 1ns/100ps
`default_nettype none

module fwsr_flash_model (
	// bench control
	input wire logic aclk,
	input wire logic load,
	input wire logic [7:0] nrd,
	input wire logic fmode,
	input wire logic ers,
	input wire logic [15:0] arr,
	output logic [15:0] last_wr,
	// flash pins
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	output logic [15:0] flash_dq_i,
	output logic ready_busy_pin
);
	logic busy_q = 0, fail_q = 0, tog_q = 0, rd_q = 0, wr_q = 0, ers_q = 0;
	logic [1:0] win_q = 0;
	logic [7:0] left_q = 0;
	logic [15:0] hold_q = 0, val;
	wire rd = !flash_ce_n && !flash_oe_n;
	wire wr = !flash_ce_n && !flash_we_n;

	////////////////////////////////////////////////////////////////////
	// poll bit, toggles, fail bit, erase window timer bit
	assign val = busy_q ? {8'h00,
		ers_q ? 1'b0 : ~arr[7], tog_q, fail_q,
		1'b0, win_q == 2'd0, tog_q, 2'b00} : arr;
	// released bus shows no stale data
	assign flash_dq_i = rd ? val : ~hold_q;
	assign ready_busy_pin = !busy_q;

	always @(posedge aclk) begin
		rd_q <= rd;
		wr_q <= wr;
		if (rd)
			hold_q <= val;
		if (wr)
			last_wr <= flash_dq_o;
		if (load) begin
			busy_q <= 1;
			fail_q <= 0;
			left_q <= nrd;
			ers_q <= ers;
			win_q <= ers ? 2'd2 : 2'd0;
		end else if (rd_q && !rd && busy_q) begin
			tog_q <= !tog_q;
			if (win_q != 0)
				win_q <= win_q - 2'd1;
			if (left_q != 0)
				left_q <= left_q - 8'h01;
			else if (fmode)
				fail_q <= 1;
			else
				busy_q <= 0;
		end else if (wr_q && !wr && (fail_q || !busy_q)) begin
			// other writes are ignored here; a write while busy, not failed, only restarts an open window
			if (last_wr == 16'h00F0) begin
				busy_q <= 0;
				fail_q <= 0;
			end
		end else if (wr_q && !wr && win_q != 0) begin
			// an added sector command restarts the whole window
			win_q <= 2'd2;
		end
	end
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
// testbench: drives fwsr_ctrl over axi4-lite against a flash model
// assumes the model answers at once; no count needs shortening
`timescale 1ns/100ps
`default_nettype none
`include "fwsr_defs.vh"

module testbench;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_awaddr = 0, s_araddr = 0;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
	logic s_arvalid = 0, s_rready = 0;
	logic [31:0] s_wdata = 0, rv;
	logic [3:0] s_wstrb = 4'hf;
	logic [1:0] rr;
	logic load = 0, fmode = 0, ers = 0;
	logic [7:0] nrd = 0;
	logic [15:0] arr = 0, w;
	wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	wire [1:0] s_bresp, s_rresp;
	wire [31:0] s_rdata;
	wire [19:0] flash_addr;
	wire [15:0] flash_dq_i, flash_dq_o, last_wr;
	wire flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, ready_busy_pin;
	int fails = 0, checked = 0;

	fwsr_ctrl u_fwsr_ctrl (.*);
	fwsr_flash_model u_fwsr_flash_model (.*);

	initial begin
		forever #10 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [31:0] exp_st(input logic ok, fl, pend);
		return {24'h00_0000, pend, 4'h0, fl, ok, 1'b0};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 0;
			if (s_wready) s_wvalid <= 0;
		end while (!s_bvalid);
		r = s_bresp;
		s_bready <= 0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1;
		s_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 0;
		end while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 0;
	endtask

	// read status until busy drops; only the watchdog ends a hang
	task automatic wait_idle();
		do begin
			rd(`FWSR_REG_STATUS, rv, rr);
		end while (rv[0]);
	endtask

	// start an op and wait for its end
	task automatic op(input logic [2:0] c, input logic cont);
		wr(`FWSR_REG_CTRL, {23'h0, cont, 5'h0, c}, rr);
		wait_idle();
	endtask

	task automatic start(input logic [7:0] n, input logic f, e);
		@(posedge aclk);
		nrd <= n;
		fmode <= f;
		ers <= e;
		arr <= 16'($urandom);
		load <= 1;
		@(posedge aclk);
		load <= 0;
		// let ready_busy_pin pass the two synchroniser stages
		repeat (2) @(posedge aclk);
	endtask

	task automatic array_chk();
		op(`FWSR_OP_READ, 0);
		rd(`FWSR_REG_RDATA, rv, rr);
		chk("array", rv, {16'h0000, arr});
	endtask

	task wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(82));
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(`FWSR_REG_STATUS, rv, rr);
		chk("status_rst", rv, 32'h0000_0020);
		rd(8'h20, rv, rr);
		chk("unmapped_rd", 32'(rr), 32'(`FWSR_RESP_SLVERR));
		wr(8'h20, 32'h0000_0000, rr);
		chk("unmapped_wr", 32'(rr), 32'(`FWSR_RESP_SLVERR));
		w = 16'($urandom);
		wr(`FWSR_REG_ADDR, {12'h000, 20'($urandom)}, rr);
		wr(`FWSR_REG_WDATA, {16'h0000, w}, rr);
		op(`FWSR_OP_WRITE, 0);
		chk("flash_wr", {16'h0000, last_wr}, {16'h0000, w});
		// still busy after one pair: pending, then resume from a pair
		start(8'd20, 0, 0);
		rd(`FWSR_REG_STATUS, rv, rr);
		chk("busy_pin", 32'(rv[5]), 32'h0000_0000);
		op(`FWSR_OP_POLL, 0);
		chk("pending", rv & 32'h0000_0087, exp_st(0, 0, 1));
		chk("tog2", 32'(rv[6]), 32'h0000_0001);
		op(`FWSR_OP_POLL, 1);
		chk("resumed", rv & 32'h0000_0087, exp_st(1, 0, 0));
		array_chk();
		// fail bit rises while toggling goes on
		start(8'd1, 1, 0);
		op(`FWSR_OP_POLL, 1);
		chk("fail", rv & 32'h0000_0087, exp_st(0, 1, 0));
		chk("reset_cmd", 32'(last_wr), 32'(`FWSR_RESET_CMD));
		array_chk();
		// sector erase: an added command is taken while the window is open
		start(8'd60, 0, 1);
		wr(`FWSR_REG_WDATA, 32'h0000_0030, rr);
		op(`FWSR_OP_SECTOR, 0);
		chk("acc", 32'(rv[4]), 32'h0000_0000);
		chk("window", 32'(rv[3]), 32'h0000_0000);
		chk("sect_wr", 32'(last_wr), 32'h0000_0030);
		// timer bit high after the window: a further command is refused
		op(`FWSR_OP_TIMER, 0);
		op(`FWSR_OP_TIMER, 0);
		chk("timer", 32'(rv[3]), 32'h0000_0001);
		wr(`FWSR_REG_WDATA, 32'h0000_0031, rr);
		op(`FWSR_OP_SECTOR, 0);
		chk("not_acc", 32'(rv[4]), 32'h0000_0001);
		chk("no_wr", 32'(last_wr), 32'h0000_0030);
		// abort ends continuous polling with the pending flag
		wr(`FWSR_REG_CTRL, 32'h0000_0103, rr);
		wr(`FWSR_REG_CTRL, 32'h0000_0200, rr);
		wait_idle();
		chk("abort", rv & 32'h0000_0087, exp_st(0, 0, 1));
		op(`FWSR_OP_POLL, 1);
		// random busy lengths, done through continuous polling
		repeat (5) begin
			start(8'($urandom_range(6)), 0, 0);
			op(`FWSR_OP_POLL, 1);
			chk("rnd_ok", rv & 32'h0000_0087, exp_st(1, 0, 0));
			chk("rdy_done", 32'(rv[5]), 32'h0000_0001);
			array_chk();
		end
		wrap_up;
	end

	initial begin
		#800000;
		fails++;
		wrap_up;
	end
endmodule

`default_nettype wire
